// File: dv/pif_flags_sva.sv
// Purpose: port checks on the flag block
// Assumes: one clock, zero wait bus, data phase one cycle after address
// Notes: upper address bits left zero by the bench
module pif_flags_sva
    import pif_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Events and configuration
    input wire logic conv_done,
    input wire logic timer_one_overflow,
    input wire logic osc_fail,
    input wire logic brownout_reset,
    input wire logic [1:0] config_brownout_field,
    // Outputs
    input wire logic brownout_detect_enable,
    input wire logic low_power_wake_enable,
    input wire logic periph_irq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Read address phase of one register
    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
    endsequence
    property p_bus;
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
    property p_unmap;
        s_rd(8'h40) |=> hrdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_f2low;
        s_rd(PIF_OFS_FLAGS2) |=> hrdata[3:0] == 4'h0;
    endproperty
    a_f2low: assert property (p_f2low) else $error("unused flag bits set");
    property p_adc;
        conv_done ##1 s_rd(PIF_OFS_FLAGS1) |=> hrdata[PIF_B_ADC];
    endproperty
    a_adc: assert property (p_adc) else $error("conversion flag missing");
    property p_timer_one_count;
        timer_one_overflow ##1 s_rd(PIF_OFS_FLAGS1) |=> hrdata[PIF_B_TIMER_ONE_COUNT];
    endproperty
    a_timer_one_count: assert property (p_timer_one_count) else $error("overflow flag missing");
    property p_osf;
        osc_fail ##1 s_rd(PIF_OFS_FLAGS2) |=> hrdata[PIF_B_OSF];
    endproperty
    a_osf: assert property (p_osf) else $error("oscillator flag missing");
    property p_bor;
        brownout_reset ##1 s_rd(PIF_OFS_PWR) |=> !hrdata[PIF_B_BOR];
    endproperty
    a_bor: assert property (p_bor) else $error("brown-out bit not cleared");
    property p_lpw;
        s_rd(PIF_OFS_PWR) |=> ##1 low_power_wake_enable == $past(hrdata[PIF_B_ULPW]);
    endproperty
    a_lpw: assert property (p_lpw) else $error("wake enable differs");
    property p_bde;
        config_brownout_field != 2'b01 |=>
            brownout_detect_enable == $past(config_brownout_field[1]);
    endproperty
    a_bde: assert property (p_bde) else $error("detect enable wrong");
    property p_irq;
        periph_irq |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("request not forwarded");
endmodule

bind pif_flags pif_flags_sva chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
    .timer_one_overflow(timer_one_overflow), .osc_fail(osc_fail),
    .brownout_reset(brownout_reset), .config_brownout_field(config_brownout_field),
    .brownout_detect_enable(brownout_detect_enable),
    .low_power_wake_enable(low_power_wake_enable), .periph_irq(periph_irq), .irq(irq));

// File: dv/pif_periph_model.sv
// Purpose: stand-in for the on-chip peripherals feeding the flag block
// Assumes: bench commands arrive one cycle ahead of the event
// Notes: events last exactly one cycle; comparator outputs are levels
module pif_periph_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic [6:0] kick,
    input wire logic [1:0] flip,
    // Towards the block
    output logic [6:0] ev,
    output logic [1:0] cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered so each event follows its bench command one cycle later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev <= 7'h00;
            cmp <= 2'h0;
        end
        else
        begin
            ev <= kick;
            cmp <= cmp ^ flip;
        end
    end
endmodule

// File: dv/tb_pif_flags.sv
// Purpose: self-checking bench for the flag block
// Assumes: bench is the only bus master; peripheral events and comparator levels come from the model
// Notes: waits on hreadyout; a cycle ceiling cuts hangs short
module tb_pif_flags;
    import pif_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, brownout_reset;
    logic serial_rx_full, serial_tx_empty, rx_rd, tx_wr, bde, lpw, periph_irq, irq;
    logic [1:0] htrans, flip, cmp, config_brownout_field;
    logic [2:0] hsize;
    logic [6:0] kick, ev;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;

    pif_periph_model model (.clk, .rst_n, .kick, .flip, .ev, .cmp);
    pif_flags dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
        .hwdata, .hrdata, .hreadyout, .hresp, .conv_done(ev[0]),
        .sync_serial_done(ev[1]), .capture_compare_event(ev[2]),
        .timer_two_match(ev[3]), .timer_one_overflow(ev[4]), .osc_fail(ev[5]),
        .nv_write_done(ev[6]), .serial_rx_full, .serial_tx_empty,
        .comparator_one_output(cmp[0]), .comparator_two_output(cmp[1]),
        .brownout_reset, .config_brownout_field, .serial_rx_data_reg_read(rx_rd),
        .serial_tx_data_reg_write(tx_wr), .brownout_detect_enable(bde),
        .low_power_wake_enable(lpw), .periph_irq, .irq);

    always #4 clk = ~clk;

    // The only slave's ready is the bus ready
    assign hready = hreadyout;

    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far above the run length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            close_out;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    // Single word transfer; address held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= PIF_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic pulse(input logic [6:0] k, input logic [1:0] f);
        @(posedge clk);
        kick <= k;
        flip <= f;
        @(posedge clk);
        kick <= 7'h00;
        flip <= 2'h0;
    endtask

    task automatic t_reset;
        rd(PIF_OFS_PWR, 32'h10);
        rd(PIF_OFS_FLAGS1, 32'h0);
        rd(PIF_OFS_FLAGS2, 32'h0);
        rd(8'h40, 32'h0);
    endtask

    task automatic t_events;
        pulse(7'h1f, 2'h3);
        rd(PIF_OFS_FLAGS1, 32'h4f);
        pulse(7'h60, 2'h0);
        rd(PIF_OFS_FLAGS2, 32'hf0);
        bus(1'b1, PIF_OFS_FLAGS2, 32'hf0);
        rd(PIF_OFS_FLAGS2, 32'hf0);
        // Clear commits on the same edge that samples the conversion event
        fork
            bus(1'b1, PIF_OFS_FLAGS1, 32'h0);
            pulse(7'h01, 2'h0);
        join
        rd(PIF_OFS_FLAGS1, 32'h40);
        bus(1'b1, PIF_OFS_FLAGS1, 32'h0);
        bus(1'b1, PIF_OFS_FLAGS2, 32'h0);
        rd(PIF_OFS_FLAGS1, 32'h0);
        rd(PIF_OFS_FLAGS2, 32'h0);
    endtask

    task automatic t_serial;
        serial_rx_full <= 1'b1;
        serial_tx_empty <= 1'b1;
        repeat (4) @(posedge clk);
        rd(PIF_OFS_FLAGS1, 32'h30);
        bus(1'b1, PIF_OFS_FLAGS1, 32'h30);
        rd(PIF_OFS_FLAGS1, 32'h30);
        // Data register access holds the matching level flag low
        rx_rd <= 1'b1;
        repeat (2) @(posedge clk);
        rd(PIF_OFS_FLAGS1, 32'h10);
        rx_rd <= 1'b0;
        tx_wr <= 1'b1;
        repeat (2) @(posedge clk);
        rd(PIF_OFS_FLAGS1, 32'h20);
        tx_wr <= 1'b0;
        serial_tx_empty <= 1'b0;
        repeat (4) @(posedge clk);
        rd(PIF_OFS_FLAGS1, 32'h20);
        serial_rx_full <= 1'b0;
    endtask

    task automatic t_pwr;
        config_brownout_field <= 2'h1;
        bus(1'b1, PIF_OFS_PWR, 32'h23);
        rd(PIF_OFS_PWR, 32'h23);
        repeat (2) @(posedge clk);
        chb(bde, 1'b0);
        chb(lpw, 1'b1);
        bus(1'b1, PIF_OFS_PWR, 32'hff);
        rd(PIF_OFS_PWR, 32'h33);
        repeat (2) @(posedge clk);
        chb(bde, 1'b1);
        config_brownout_field <= 2'h0;
        repeat (2) @(posedge clk);
        chb(bde, 1'b0);
        config_brownout_field <= 2'h3;
        // Brown-out stands one cycle ahead of the read's address phase
        brownout_reset <= 1'b1;
        rd(PIF_OFS_PWR, 32'h32);
        brownout_reset <= 1'b0;
        chb(bde, 1'b1);
    endtask

    task automatic t_irq;
        // Flags are clear before any enable is set
        bus(1'b1, PIF_OFS_EN1, 32'h40);
        pulse(7'h01, 2'h0);
        repeat (4) @(posedge clk);
        chb(periph_irq, 1'b0);
        bus(1'b1, PIF_OFS_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        chb(periph_irq, 1'b1);
        chb(irq, 1'b1);
        bus(1'b1, PIF_OFS_FLAGS1, 32'h0);
        bus(1'b1, PIF_OFS_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        chb(irq, 1'b0);
        bus(1'b1, PIF_OFS_IMASK, 32'h1);
        repeat (4) @(posedge clk);
        chb(irq, 1'b1);
        rd(PIF_OFS_IST, 32'h3);
        repeat (4) @(posedge clk);
        chb(irq, 1'b0);
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {hsel, hwrite, brownout_reset, serial_rx_full, serial_tx_empty} = 5'h00;
        {rx_rd, tx_wr, flip, kick, config_brownout_field} = 13'h0000;
        hsize = 3'h2;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_events;
        t_serial;
        t_pwr;
        t_irq;
        close_out;
    end
endmodule

// File: rtl/pif_ahb_slave.sv
// Purpose: AHB-Lite slave turning transfers into register strobes
// Assumes: single word transfers, zero wait states
// Notes: always answers OKAY; read data comes from core registers
module pif_ahb_slave
    import pif_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register strobes
    pif_reg_if.slave rif
);
    typedef struct packed {
        logic wpend;
        logic [7:0] waddr;
        logic [31:0] rdata;
    } pif_ahb_st_t;
    pif_ahb_st_t q, d;
    logic take;

    // Address phase accepted when selected and active
    assign take = hsel && hready && (htrans == PIF_HTRANS_NONSEQ || htrans == PIF_HTRANS_SEQ);

    // Reads strobe in the address phase so data stands in the data phase
    always_comb
    begin
        d = q;
        d.wpend = take && hwrite;
        if (take)
        begin
            d.waddr = haddr[7:0];
        end
        // Captured before a read-clear lands, so the cleared bits are still seen
        if (take && !hwrite)
        begin
            d.rdata = rif.rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Write commits in the data phase when hwdata stands
    assign rif.wr = q.wpend;
    assign rif.rd = take && !hwrite;
    assign rif.addr = q.wpend ? q.waddr : haddr[7:0];
    assign rif.wdata = hwdata[7:0];
    assign hrdata = q.rdata; // Stands from a flop through the data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// File: rtl/pif_flags.sv
// Contract
// [R01] Conversion done sets flag, software clears
// [R02] Receive flag follows buffer full, read-only
// [R03] Transmit flag follows buffer empty, read-only
// [R04] Sync serial completion sets sticky flag
// [R05] Capture or compare event sets flag
// [R06] Timer-two period match sets sticky flag
// [R07] Timer-one overflow sets bit zero
// [R08] Flags set regardless of enable bits
// [R09] Software clears flags before enabling interrupts
// [R10] Oscillator fail sets bit seven
// [R11] Comparator output changes set bits six, five
// [R12] Write completion sets bit four; rest zero
// [R13] Power-on reset clears power-on status bit
// [R14] Brown-out reset clears brown-out status bit
// [R15] Soft brown-out enable acts when field 01
// [R16] Wake-up enable bit drives wake-up function
// [R17] Peripheral enable gates every flag interrupt; irq still fires from the REQ status bit when imask allows it
// [R18] Request needs flag and enable; set wins
//
// Purpose: peripheral request flags, power/reset status and interrupt output
// Assumes: event inputs are one-cycle pulses on clk; levels come from pins
// Notes: rst_n is the power-on reset; brownout_reset is a separate pulse input
module pif_flags
    import pif_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite register port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Peripheral events, one-cycle pulses
    input wire logic conv_done,
    input wire logic sync_serial_done,
    input wire logic capture_compare_event,
    input wire logic timer_two_match,
    input wire logic timer_one_overflow,
    input wire logic osc_fail,
    input wire logic nv_write_done,
    // Peripheral levels from outside the domain
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    // Reset sources and configuration
    input wire logic brownout_reset,
    input wire logic [1:0] config_brownout_field,
    // Data register access notices
    input wire logic serial_rx_data_reg_read,
    input wire logic serial_tx_data_reg_write,
    // Outputs
    output logic brownout_detect_enable,
    output logic low_power_wake_enable,
    output logic periph_irq,
    output logic irq
);
    pif_reg_if rif();

    typedef struct packed {
        logic [7:0] flags1;
        logic [7:0] flags2;
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] pwr;
        logic peripheral_irq_enable;
        logic [1:0] rx_s;
        logic [1:0] tx_s;
        logic [1:0] c1_s;
        logic [1:0] c2_s;
        logic c1_prev;
        logic c2_prev;
        logic sync_done;
        logic [PIF_NEV-1:0] ist;
        logic [PIF_NEV-1:0] imask;
        logic bor_en;
        logic ulpw;
        logic pirq;
        logic irq;
    } pif_st_t;
    pif_st_t q, d;
    logic [7:0] set1, set2, clr1, clr2;
    logic [31:0] rdata;

    // Sticky update: the hardware set wins over the software clear
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                          input logic [7:0] clr);
        sticky = (cur & ~clr) | set;
    endfunction

    // Register read mux, reserved bits read as zero
    function automatic logic [31:0] rd_mux(input logic [7:0] a, input pif_st_t s,
                                           input logic [7:0] f1);
        rd_mux = '0;
        case (a)
            PIF_OFS_FLAGS1: rd_mux[7:0] = f1;
            PIF_OFS_FLAGS2: rd_mux[7:0] = s.flags2;
            PIF_OFS_PWR: rd_mux[7:0] = s.pwr;
            PIF_OFS_EN1: rd_mux[7:0] = s.en1;
            PIF_OFS_EN2: rd_mux[7:0] = s.en2;
            PIF_OFS_CTRL: rd_mux[PIF_B_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
            PIF_OFS_IST: rd_mux[PIF_NEV-1:0] = s.ist;
            PIF_OFS_IMASK: rd_mux[PIF_NEV-1:0] = s.imask;
            default: rd_mux = '0;
        endcase
    endfunction

    pif_ahb_slave u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rif(rif.slave)
    );

    // Event set vectors; enables play no part here
    always_comb
    begin
        set1 = '0;
        set2 = '0;
        // [R08] enable-independent setting
        // [R01] conversion done
        set1[PIF_B_ADC] = conv_done;
        // [R04] sync serial completion
        set1[PIF_B_SSP] = sync_serial_done;
        // [R05] capture or compare hit
        set1[PIF_B_CCP] = capture_compare_event;
        // [R06] period match
        set1[PIF_B_TMR2] = timer_two_match;
        // [R07] count overflow
        set1[PIF_B_TIMER_ONE_COUNT] = timer_one_overflow;
        // [R10] oscillator failure
        set2[PIF_B_OSF] = osc_fail;
        // [R11] comparator output edges, synchronised copies only
        set2[PIF_B_CMP2] = q.c2_s[1] ^ q.c2_prev;
        set2[PIF_B_CMP1] = q.c1_s[1] ^ q.c1_prev;
        // [R12] write completion
        set2[PIF_B_NVW] = nv_write_done;
    end

    // Software writes of zero clear sticky flags; ones are ignored
    assign clr1 = (rif.wr && rif.addr == PIF_OFS_FLAGS1) ? (~rif.wdata & PIF_F1_SWMASK) : 8'h00;
    assign clr2 = (rif.wr && rif.addr == PIF_OFS_FLAGS2) ? (~rif.wdata & PIF_F2_SWMASK) : 8'h00;

    // Read data; the interrupt status read clears its bits
    assign rdata = rd_mux(rif.addr, q, q.flags1);
    assign rif.rdata = q.sync_done ? rdata : rdata;

    always_comb
    begin
        d = q;
        // Level inputs cross through two flops before any use
        d.rx_s = {q.rx_s[0], serial_rx_full};
        d.tx_s = {q.tx_s[0], serial_tx_empty};
        d.c1_s = {q.c1_s[0], comparator_one_output};
        d.c2_s = {q.c2_s[0], comparator_two_output};
        d.c1_prev = q.c1_s[1];
        d.c2_prev = q.c2_s[1];
        d.sync_done = 1'b1;
        d.flags1 = sticky(q.flags1, set1, clr1);
        // [R02] receive flag mirrors buffer state
        d.flags1[PIF_B_RXF] = q.rx_s[1] && !serial_rx_data_reg_read;
        // [R03] transmit flag mirrors buffer state
        d.flags1[PIF_B_TXE] = q.tx_s[1] && !serial_tx_data_reg_write;
        d.flags1[7] = 1'b0;
        // [R12] unimplemented bits stay zero
        d.flags2 = sticky(q.flags2, set2, clr2) & PIF_F2_SWMASK;
        if (!q.sync_done)
        begin
            // Comparator history is not valid until the synchroniser fills
            d.flags2[PIF_B_CMP2] = 1'b0;
            d.flags2[PIF_B_CMP1] = 1'b0;
        end
        if (rif.wr)
        begin
            case (rif.addr)
                PIF_OFS_EN1: d.en1 = rif.wdata & 8'h7f;
                PIF_OFS_EN2: d.en2 = rif.wdata & PIF_F2_SWMASK;
                PIF_OFS_PWR: d.pwr = rif.wdata & PIF_PWR_WMASK;
                PIF_OFS_CTRL: d.peripheral_irq_enable = rif.wdata[PIF_B_PERIPHERAL_IRQ_ENABLE];
                PIF_OFS_IMASK: d.imask = rif.wdata[PIF_NEV-1:0];
                default: d.pwr = d.pwr;
            endcase
        end
        // [R14] brown-out reset clears its status bit
        if (brownout_reset)
        begin
            d.pwr[PIF_B_BOR] = 1'b0;
        end
        // [R15] software enable only with field 01
        d.bor_en = (config_brownout_field == 2'h1) ? q.pwr[PIF_B_SBOR]
                                                 : config_brownout_field[1];
        // [R16] wake-up enable follows its bit
        d.ulpw = q.pwr[PIF_B_ULPW];
        // Block status: read clears, a new event in the same cycle wins
        if (rif.rd && rif.addr == PIF_OFS_IST)
        begin
            d.ist = '0;
        end
        d.ist[PIF_EV_REQ] = d.ist[PIF_EV_REQ] || (|set1) || (|set2);
        d.ist[PIF_EV_ROW] = d.ist[PIF_EV_ROW]
                            || (rif.wr && rif.addr == PIF_OFS_FLAGS1 && rif.wdata[5:4] != 2'h0);
        // [R18] request needs flag and enable
        // [R17] peripheral enable gates pirq; irq still fires from the REQ status bit when imask allows it
        d.pirq = q.peripheral_irq_enable && (|(q.flags1 & q.en1) || |(q.flags2 & q.en2));
        d.irq = |(q.ist & q.imask) || q.pirq;
    end

    // [R13] power-on reset clears the power-on status bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.pwr <= PIF_PWR_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign brownout_detect_enable = q.bor_en;
    assign low_power_wake_enable = q.ulpw;
    assign periph_irq = q.pirq;
    assign irq = q.irq;
endmodule

// File: rtl/pif_pkg.sv
// Purpose: shared constants and types for the peripheral request flag block
// Assumes: AHB-Lite register port, 32-bit data, one word per register
// Notes: register offsets are byte addresses
package pif_pkg;
    // Register byte offsets
    localparam logic [7:0] PIF_OFS_FLAGS1 = 8'h00;
    localparam logic [7:0] PIF_OFS_FLAGS2 = 8'h04;
    localparam logic [7:0] PIF_OFS_PWR = 8'h08;
    localparam logic [7:0] PIF_OFS_EN1 = 8'h0c;
    localparam logic [7:0] PIF_OFS_EN2 = 8'h10;
    localparam logic [7:0] PIF_OFS_CTRL = 8'h14;
    localparam logic [7:0] PIF_OFS_IST = 8'h18;
    localparam logic [7:0] PIF_OFS_IMASK = 8'h1c;
    // Request register one bit positions
    localparam int PIF_B_TIMER_ONE_COUNT = 0;
    localparam int PIF_B_TMR2 = 1;
    localparam int PIF_B_CCP = 2;
    localparam int PIF_B_SSP = 3;
    localparam int PIF_B_TXE = 4;
    localparam int PIF_B_RXF = 5;
    localparam int PIF_B_ADC = 6;
    // Request register two bit positions
    localparam int PIF_B_NVW = 4;
    localparam int PIF_B_CMP1 = 5;
    localparam int PIF_B_CMP2 = 6;
    localparam int PIF_B_OSF = 7;
    // Power register bit positions
    localparam int PIF_B_BOR = 0;
    localparam int PIF_B_POR = 1;
    localparam int PIF_B_SBOR = 4;
    localparam int PIF_B_ULPW = 5;
    // Control register bit position
    localparam int PIF_B_PERIPHERAL_IRQ_ENABLE = 0;
    // Software-clearable bits and reset values
    localparam logic [7:0] PIF_F1_SWMASK = 8'h4f;
    localparam logic [7:0] PIF_F2_SWMASK = 8'hf0;
    localparam logic [7:0] PIF_PWR_RST = 8'h10;
    localparam logic [7:0] PIF_PWR_WMASK = 8'h33;
    // Block event status bits: hardware flag, wrote to read-only bit
    localparam int PIF_NEV = 2;
    localparam int PIF_EV_REQ = 0;
    localparam int PIF_EV_ROW = 1;
    // AHB encodings
    localparam logic [1:0] PIF_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PIF_HTRANS_SEQ = 2'h3;
endpackage

// File: rtl/pif_reg_if.sv
// Purpose: register access strobes between the bus slave and flag core
// Assumes: one clock, one access per cycle
// Notes: write data stands only in the cycle of wr
interface pif_reg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, output rd, output addr, output wdata, input rdata);
    modport core (input wr, input rd, input addr, input wdata, output rdata);
endinterface
